// ==== cpu_arith_logic_jump_unit.sv ====
// execution unit top: wishbone slave, register file, sequencer, program counter and return stack
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_exec_defines.svh"

// Overview of operation
// - add registers, five flags, one cycle
// - add with carry, five flags, one cycle
// - subtract register or constant, one cycle
// - subtract with borrow, both forms, one cycle
// - word add/subtract immediate on pair, two cycles
// - and/or/xor update only Z N V
// - bit set and clear by mask
// - invert: 0xFF minus value, sets carry
// - negate: zero minus value, one cycle
// - increment/decrement keep carry untouched
// - test ANDs register with itself
// - clear via xor; set loads 0xFF, no flags
// - products into R1:R0, Z and C, two cycles
// - fractional products shifted left one bit
// - relative jump/entry: pc plus offset plus one
// - pointer jump to Z pair, two cycles
// - pointer entry to Z pair, three cycles
module cpu_arith_logic_jump_unit
   import cpu_exec_pkg::*;
#(
   parameter int STACK_DEPTH = 16
)
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic BUSY,
   output logic [15:0] PC
);

   localparam int SPW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            m[8*i +: 8] = nw[8*i +: 8];
      end
      return m;
   endfunction

   function automatic logic [2:0] cycles_of(input op_t op);
      logic [2:0] n;
      case (op)
         OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE: n = `CYC_WORD;
         OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
         OP_FRAC_UNSIGNED_PRODUCT, OP_FRAC_SIGNED_PRODUCT, OP_FRAC_MIXED_PRODUCT: n = `CYC_PROD;
         OP_RELATIVE_JUMP: n = `CYC_REL_JUMP;
         OP_POINTER_JUMP: n = `CYC_PTR_JUMP;
         OP_ABSOLUTE_JUMP: n = `CYC_ABS_JUMP;
         OP_RELATIVE_SUBROUTINE_ENTRY: n = `CYC_REL_CALL;
         OP_POINTER_SUBROUTINE_ENTRY: n = `CYC_PTR_CALL;
         OP_ABSOLUTE_SUBROUTINE_ENTRY: n = `CYC_ABS_CALL;
         default: n = `CYC_SINGLE;
      endcase
      return n;
   endfunction

   logic ack_ff;
   logic [31:0] rdat_ff;
   logic [7:0] rf_ff [32];
   logic [7:0] sreg_ff;
   logic [15:0] pc_ff;
   logic [15:0] imm_ff;
   op_t op_ff;
   logic [4:0] rd_ff;
   logic [4:0] src_ff;
   logic [2:0] cnt_ff;
   logic [2:0] last_cyc_ff;
   logic rej_ff;
   logic busy_ff;
   st_t state_ff;
   logic [15:0] stack_ff [STACK_DEPTH];
   logic [SPW-1:0] sp_ff;

   // bus decode
   wire logic req = WB_CYC_I & WB_STB_I;
   // a write lands on the edge where the master samples ack, never earlier
   wire logic wr_take = req & WB_WE_I & ack_ff;
   wire logic idle = (state_ff == ST_IDLE);
   wire logic [7:0] adr = {WB_ADR_I[7:2], 2'b00};
   wire logic hit_cmd = (adr == `ADDR_CMD);
   wire logic hit_imm = (adr == `ADDR_IMM);
   wire logic hit_sreg = (adr == `ADDR_SREG);
   wire logic hit_pc = (adr == `ADDR_PC);
   wire logic hit_stack = (adr == `ADDR_STACK);
   wire logic hit_status = (adr == `ADDR_STATUS);
   wire logic hit_rf = (adr >= `ADDR_RF_BASE);
   wire logic [4:0] rf_idx = WB_ADR_I[6:2];

   // command word
   wire logic [31:0] cmd_word = lane_merge(32'h0000_0000, WB_DAT_I, WB_SEL_I);
   wire logic [5:0] cmd_op = cmd_word[`CMD_OP_LSB +: 6];
   wire logic cmd_legal = (cmd_op <= 6'(OP_ABSOLUTE_SUBROUTINE_ENTRY));
   wire logic cmd_wr = wr_take & hit_cmd;
   // a command while busy or with an unknown code is dropped, not queued
   wire logic start = cmd_wr & idle & cmd_legal;
   wire op_t new_op = op_t'(cmd_op);
   wire logic [2:0] new_cyc = cycles_of(new_op);

   // state and operands hold still while busy, so the result is computed at commit
   wire logic fin = (state_ff == ST_EXEC) & (cnt_ff == 3'h0);
   wire logic [4:0] rd_hi = 5'(rd_ff + 5'h01);
   wire logic [7:0] dval = rf_ff[rd_ff];
   wire logic [7:0] rval = rf_ff[src_ff];
   wire logic [15:0] pair = {rf_ff[rd_hi], rf_ff[rd_ff]};
   wire logic [15:0] zptr = {rf_ff[31], rf_ff[30]};

   logic [15:0] res;
   logic wr_lo;
   logic wr_hi;
   logic to_r1r0;
   logic [7:0] sreg_nxt;

   arith_unit u_arith (
      .op(op_ff),
      .dval(dval),
      .rval(rval),
      .kval(imm_ff[7:0]),
      .pair(pair),
      .kword(imm_ff[5:0]),
      .sreg_in(sreg_ff),
      .res(res),
      .wr_lo(wr_lo),
      .wr_hi(wr_hi),
      .to_r1r0(to_r1r0),
      .sreg_out(sreg_nxt)
   );

   wire logic [4:0] lo_idx = to_r1r0 ? 5'h00 : rd_ff;
   wire logic [4:0] hi_idx = to_r1r0 ? 5'h01 : rd_hi;

   // flow control
   wire logic [15:0] rel_off = {{4{imm_ff[11]}}, imm_ff[11:0]};
   wire logic [15:0] rel_tgt = 16'(pc_ff + rel_off + `PC_STEP_SHORT);
   wire logic is_rel = (op_ff == OP_RELATIVE_JUMP) | (op_ff == OP_RELATIVE_SUBROUTINE_ENTRY);
   wire logic is_ptr = (op_ff == OP_POINTER_JUMP) | (op_ff == OP_POINTER_SUBROUTINE_ENTRY);
   wire logic is_abs = (op_ff == OP_ABSOLUTE_JUMP) | (op_ff == OP_ABSOLUTE_SUBROUTINE_ENTRY);
   wire logic is_call = (op_ff == OP_RELATIVE_SUBROUTINE_ENTRY) | (op_ff == OP_POINTER_SUBROUTINE_ENTRY) |
                        (op_ff == OP_ABSOLUTE_SUBROUTINE_ENTRY);
   // the absolute forms occupy two program words
   wire logic [15:0] ret_addr = 16'(pc_ff + (is_abs ? `PC_STEP_LONG : `PC_STEP_SHORT));
   wire logic [15:0] nxt_pc = is_rel ? rel_tgt :
                              is_ptr ? zptr :
                              is_abs ? imm_ff : ret_addr;
   wire logic [SPW-1:0] sp_top = SPW'(sp_ff - 1'b1);

   // read mux
   wire logic [31:0] rd_mux =
      hit_cmd ? {11'h000, src_ff, 3'h0, rd_ff, 2'h0, 6'(op_ff)} :
      hit_imm ? {16'h0000, imm_ff} :
      hit_sreg ? {24'h00_0000, sreg_ff} :
      hit_pc ? {16'h0000, pc_ff} :
      hit_stack ? {16'(sp_ff), stack_ff[sp_top]} :
      hit_status ? {21'h00_0000, last_cyc_ff, 6'h00, rej_ff, busy_ff} :
      hit_rf ? {24'h00_0000, rf_ff[rf_idx]} : 32'h0000_0000;

   // wishbone slave: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end
      else
      begin
         ack_ff <= req & ~ack_ff;
         if (req & ~ack_ff)
            rdat_ff <= rd_mux;
      end
   end

   assign WB_ACK_O = ack_ff;
   assign WB_DAT_O = rdat_ff;
   assign BUSY = busy_ff;
   assign PC = pc_ff;

   // sequencer
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state_ff <= ST_IDLE;
         busy_ff <= 1'b0;
         cnt_ff <= 3'h0;
         op_ff <= OP_ADD;
         rd_ff <= 5'h00;
         src_ff <= 5'h00;
         last_cyc_ff <= 3'h0;
         rej_ff <= 1'b0;
      end
      else
      begin
         if (cmd_wr)
            rej_ff <= ~start;
         case (state_ff)
            ST_IDLE:
            begin
               if (start)
               begin
                  state_ff <= ST_EXEC;
                  busy_ff <= 1'b1;
                  cnt_ff <= 3'(new_cyc - 3'h1);
                  last_cyc_ff <= new_cyc;
                  op_ff <= new_op;
                  rd_ff <= cmd_word[`CMD_RD_LSB +: 5];
                  src_ff <= cmd_word[`CMD_SRC_LSB +: 5];
               end
            end
            ST_EXEC:
            begin
               if (fin)
               begin
                  state_ff <= ST_IDLE;
                  busy_ff <= 1'b0;
               end
               else
                  cnt_ff <= 3'(cnt_ff - 3'h1);
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // register file: bus writes only while idle, results at commit
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         for (int i = 0; i < 32; i++)
            rf_ff[i] <= 8'h00;
      end
      else if (idle)
      begin
         if (wr_take & hit_rf & WB_SEL_I[0])
            rf_ff[rf_idx] <= WB_DAT_I[7:0];
      end
      else if (fin)
      begin
         if (wr_lo)
            rf_ff[lo_idx] <= res[7:0];
         if (wr_hi)
            rf_ff[hi_idx] <= res[15:8];
      end
   end

   // immediate and status register
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         imm_ff <= 16'h0000;
         sreg_ff <= `SREG_RST;
      end
      else if (idle)
      begin
         if (wr_take & hit_imm)
            imm_ff <= 16'(lane_merge({16'h0000, imm_ff}, WB_DAT_I, WB_SEL_I));
         if (wr_take & hit_sreg)
            sreg_ff <= 8'(lane_merge({24'h00_0000, sreg_ff}, WB_DAT_I, WB_SEL_I));
      end
      else if (fin)
         sreg_ff <= sreg_nxt;
   end

   // program counter and return stack
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         pc_ff <= `PC_RST;
         sp_ff <= '0;
         for (int i = 0; i < STACK_DEPTH; i++)
            stack_ff[i] <= 16'h0000;
      end
      else if (idle)
      begin
         if (wr_take & hit_pc)
            pc_ff <= 16'(lane_merge({16'h0000, pc_ff}, WB_DAT_I, WB_SEL_I));
      end
      else if (fin)
      begin
         pc_ff <= nxt_pc;
         if (is_call)
         begin
            // return address is stored in the same edge the pc changes
            stack_ff[sp_ff] <= ret_addr;
            sp_ff <= SPW'(sp_ff + 1'b1);
         end
      end
   end

endmodule
`default_nettype wire

// ==== cpu_exec_defines.svh ====
// register map, field positions, flag positions and cycle counts of the execution unit
`ifndef CPU_EXEC_DEFINES_SVH
`define CPU_EXEC_DEFINES_SVH
`define ADDR_CMD 8'h00
`define ADDR_IMM 8'h04
`define ADDR_SREG 8'h08
`define ADDR_PC 8'h0C
`define ADDR_STACK 8'h10
`define ADDR_STATUS 8'h14
`define ADDR_RF_BASE 8'h80
`define CMD_OP_LSB 0
`define CMD_RD_LSB 8
`define CMD_SRC_LSB 16
`define STATUS_BUSY_BIT 0
`define STATUS_REJ_BIT 1
`define STATUS_CYC_LSB 8
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define MASK_ARITH 8'h2F
`define MASK_LOGIC 8'h0E
`define MASK_INVERT 8'h0F
`define MASK_WORD 8'h1F
`define MASK_PROD 8'h03
`define SREG_RST 8'h00
`define PC_RST 16'h0000
`define PC_STEP_SHORT 16'h0001
`define PC_STEP_LONG 16'h0002
`define CYC_SINGLE 3'h1
`define CYC_WORD 3'h2
`define CYC_PROD 3'h2
`define CYC_REL_JUMP 3'h2
`define CYC_PTR_JUMP 3'h2
`define CYC_ABS_JUMP 3'h3
`define CYC_REL_CALL 3'h3
`define CYC_PTR_CALL 3'h3
`define CYC_ABS_CALL 3'h4
`endif

// ==== cpu_exec_pkg.sv ====
// operation codes and sequencer states of the execution unit
package cpu_exec_pkg;
   typedef enum logic [5:0] {
      OP_ADD, OP_ADD_CARRY, OP_WORD_PLUS_IMMEDIATE, OP_DIFFERENCE, OP_DIFFERENCE_IMMEDIATE,
      OP_DIFFERENCE_WITH_BORROW, OP_IMMEDIATE_DIFF_BORROW, OP_WORD_MINUS_IMMEDIATE,
      OP_CONJ, OP_CONJ_IMMEDIATE, OP_DISJ, OP_DISJ_IMMEDIATE, OP_BITWISE_XDISJ,
      OP_INVERT, OP_ZERO_MINUS_REG, OP_BITS_SET_MASK, OP_BITS_CLEAR_MASK, OP_PLUS_ONE,
      OP_MINUS_ONE, OP_ZERO_SIGN_TEST, OP_ZERO_REG, OP_ALL_ONES_LOAD,
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
      OP_FRAC_UNSIGNED_PRODUCT, OP_FRAC_SIGNED_PRODUCT, OP_FRAC_MIXED_PRODUCT,
      OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_ABSOLUTE_JUMP,
      OP_RELATIVE_SUBROUTINE_ENTRY, OP_POINTER_SUBROUTINE_ENTRY, OP_ABSOLUTE_SUBROUTINE_ENTRY
   } op_t;
   typedef enum logic {ST_IDLE, ST_EXEC} st_t;
endpackage

// ==== arith_unit.sv ====
// combinational byte, word and product datapath with status flag update
`timescale 1ns/1ps
`default_nettype none
`include "cpu_exec_defines.svh"

module arith_unit
   import cpu_exec_pkg::*;
(
   input wire op_t op,
   input wire logic [7:0] dval,
   input wire logic [7:0] rval,
   input wire logic [7:0] kval,
   input wire logic [15:0] pair,
   input wire logic [5:0] kword,
   input wire logic [7:0] sreg_in,
   output logic [15:0] res,
   output logic wr_lo,
   output logic wr_hi,
   output logic to_r1r0,
   output logic [7:0] sreg_out
);

   // {h, v, c, r}
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
      logic [8:0] s;
      logic h;
      logic v;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      h = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
      v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
      return {h, v, s[8], s[7:0]};
   endfunction

   // carry out is the borrow
   function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic cin);
      logic [8:0] d;
      logic h;
      logic v;
      d = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      h = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
      return {h, v, d[8], d[7:0]};
   endfunction

   function automatic logic [15:0] mul16(input logic [7:0] a, input logic [7:0] b, input logic as,
                                         input logic bs);
      logic signed [8:0] x;
      logic signed [8:0] y;
      logic signed [17:0] p;
      x = {as & a[7], a};
      y = {bs & b[7], b};
      p = x * y;
      return p[15:0];
   endfunction

   logic [10:0] t;
   logic [16:0] w;
   logic [15:0] p;
   logic [7:0] nf;
   logic [7:0] upd;
   logic wide;
   logic chain_z;
   logic frac;

   always_comb
   begin
      t = 11'h000;
      w = 17'h0_0000;
      p = 16'h0000;
      nf = 8'h00;
      upd = 8'h00;
      wide = 1'b0;
      chain_z = 1'b0;
      frac = 1'b0;
      res = 16'h0000;
      wr_lo = 1'b0;
      wr_hi = 1'b0;
      to_r1r0 = 1'b0;
      case (op)
         OP_ADD: begin t = add8(dval, rval, 1'b0); upd = `MASK_ARITH; end
         OP_ADD_CARRY: begin t = add8(dval, rval, sreg_in[`FLAG_C]); upd = `MASK_ARITH; end
         OP_DIFFERENCE: begin t = sub8(dval, rval, 1'b0); upd = `MASK_ARITH; end
         OP_DIFFERENCE_IMMEDIATE: begin t = sub8(dval, kval, 1'b0); upd = `MASK_ARITH; end
         OP_DIFFERENCE_WITH_BORROW, OP_IMMEDIATE_DIFF_BORROW:
         begin
            // zero flag chains through multi-byte subtracts
            t = sub8(dval, (op == OP_DIFFERENCE_WITH_BORROW) ? rval : kval, sreg_in[`FLAG_C]);
            upd = `MASK_ARITH;
            chain_z = 1'b1;
         end
         OP_CONJ: begin t = {3'h0, dval & rval}; upd = `MASK_LOGIC; end
         OP_CONJ_IMMEDIATE: begin t = {3'h0, dval & kval}; upd = `MASK_LOGIC; end
         OP_DISJ: begin t = {3'h0, dval | rval}; upd = `MASK_LOGIC; end
         OP_DISJ_IMMEDIATE: begin t = {3'h0, dval | kval}; upd = `MASK_LOGIC; end
         OP_BITWISE_XDISJ: begin t = {3'h0, dval ^ rval}; upd = `MASK_LOGIC; end
         OP_BITS_SET_MASK: begin t = {3'h0, dval | kval}; upd = `MASK_LOGIC; end
         OP_BITS_CLEAR_MASK: begin t = {3'h0, dval & (8'hFF - kval)}; upd = `MASK_LOGIC; end
         OP_INVERT: begin t = {3'h1, 8'hFF - dval}; upd = `MASK_INVERT; end
         OP_ZERO_MINUS_REG: begin t = sub8(8'h00, dval, 1'b0); upd = `MASK_ARITH; end
         OP_PLUS_ONE: begin t = add8(dval, 8'h00, 1'b1); upd = `MASK_LOGIC; end
         OP_MINUS_ONE: begin t = sub8(dval, 8'h00, 1'b1); upd = `MASK_LOGIC; end
         OP_ZERO_SIGN_TEST: begin t = {3'h0, dval & dval}; upd = `MASK_LOGIC; end
         OP_ZERO_REG: begin t = {3'h0, dval ^ dval}; upd = `MASK_LOGIC; end
         OP_ALL_ONES_LOAD: t = {3'h0, 8'hFF};
         OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE:
         begin
            wide = 1'b1;
            upd = `MASK_WORD;
            wr_hi = 1'b1;
            if (op == OP_WORD_PLUS_IMMEDIATE)
            begin
               w = {1'b0, pair} + {11'h000, kword};
               nf[`FLAG_V] = ~pair[15] & w[15];
               nf[`FLAG_C] = pair[15] & ~w[15];
            end
            else
            begin
               w = {1'b0, pair} - {11'h000, kword};
               nf[`FLAG_V] = pair[15] & ~w[15];
               nf[`FLAG_C] = ~pair[15] & w[15];
            end
            res = w[15:0];
            nf[`FLAG_N] = w[15];
            nf[`FLAG_Z] = (w[15:0] == 16'h0000);
            nf[`FLAG_S] = w[15] ^ nf[`FLAG_V];
         end
         OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
         OP_FRAC_UNSIGNED_PRODUCT, OP_FRAC_SIGNED_PRODUCT, OP_FRAC_MIXED_PRODUCT:
         begin
            wide = 1'b1;
            upd = `MASK_PROD;
            wr_hi = 1'b1;
            to_r1r0 = 1'b1;
            frac = (op == OP_FRAC_UNSIGNED_PRODUCT) | (op == OP_FRAC_SIGNED_PRODUCT) |
                   (op == OP_FRAC_MIXED_PRODUCT);
            p = mul16(dval, rval, (op == OP_SIGNED_PRODUCT) | (op == OP_MIXED_SIGN_PRODUCT) |
                      (op == OP_FRAC_SIGNED_PRODUCT) | (op == OP_FRAC_MIXED_PRODUCT),
                      (op == OP_SIGNED_PRODUCT) | (op == OP_FRAC_SIGNED_PRODUCT));
            res = frac ? {p[14:0], 1'b0} : p;
            nf[`FLAG_C] = p[15];
            nf[`FLAG_Z] = (res == 16'h0000);
         end
         default: t = 11'h000;
      endcase
      if (!wide)
      begin
         res = {8'h00, t[7:0]};
         wr_lo = (op <= OP_ALL_ONES_LOAD);
         nf[`FLAG_C] = t[8];
         nf[`FLAG_V] = t[9];
         nf[`FLAG_H] = t[10];
         nf[`FLAG_N] = t[7];
         nf[`FLAG_Z] = (t[7:0] == 8'h00) & (~chain_z | sreg_in[`FLAG_Z]);
      end
      else
         wr_lo = 1'b1;
      sreg_out = (sreg_in & ~upd) | (nf & upd);
   end

endmodule
`default_nettype wire

// ==== cpu_arith_logic_jump_unit_checker.sv ====
// bus and sequencer assertions for the execution unit
`timescale 1ns/1ps
`default_nettype none
module cpu_arith_logic_jump_unit_checker
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic BUSY,
   input wire logic [15:0] PC
);
   wire logic [5:0] op = WB_DAT_I[5:0];
   wire logic take = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_ADR_I[7:2] == 6'h00 && WB_SEL_I[0] && !BUSY;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   sequence s_req;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence s_cmd;
      take ##1 WB_ACK_O;
   endsequence
   property p_ack_lat;
      s_req |=> WB_ACK_O;
   endproperty
   property p_ack_pulse;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   property p_one;
      (op inside {[0:1], [3:6], [8:21]}) ##0 s_cmd |=> BUSY ##1 !BUSY;
   endproperty
   property p_two;
      (op inside {2, 7, [22:29]}) ##0 s_cmd |=> BUSY [*2] ##1 !BUSY;
   endproperty
   property p_three;
      (op inside {[30:32]}) ##0 s_cmd |=> BUSY [*3] ##1 !BUSY;
   endproperty
   property p_four;
      (op == 6'd33) ##0 s_cmd |=> BUSY [*4] ##1 !BUSY;
   endproperty
   property p_refuse;
      take && op > 6'd33 |-> ##2 !BUSY ##1 !BUSY;
   endproperty
   property p_pc_step;
      take && (op inside {[0:1], [3:6], [8:21]}) |-> ##3 PC == $past(PC, 3) + 16'h0001;
   endproperty
   property p_pc_hold;
      BUSY ##1 BUSY |-> $stable(PC);
   endproperty
   property p_pc_idle;
      !BUSY && !$past(BUSY) && !$past(WB_ACK_O) |-> $stable(PC);
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack missing one cycle after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_one: assert property (p_one) else $error("byte op not one busy cycle");
   a_two: assert property (p_two) else $error("two-cycle op busy length wrong");
   a_three: assert property (p_three) else $error("three-cycle op busy length wrong");
   a_four: assert property (p_four) else $error("absolute entry busy length wrong");
   a_refuse: assert property (p_refuse) else $error("illegal op started");
   a_pc_step: assert property (p_pc_step) else $error("byte op did not advance pc by one");
   a_pc_hold: assert property (p_pc_hold) else $error("pc moved mid-execution");
   a_pc_idle: assert property (p_pc_idle) else $error("pc moved while idle");
endmodule
bind cpu_arith_logic_jump_unit cpu_arith_logic_jump_unit_checker chk_u (.CLK(CLK), .NRST(NRST),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
   .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .BUSY(BUSY), .PC(PC));
`default_nettype wire

// ==== cpu_arith_logic_jump_unit_bench.sv ====
// self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
module cpu_arith_logic_jump_unit_bench;
   logic clk, nrst, cyc, stb, we;
   logic [7:0] adr, d, r, k, s;
   logic [3:0] sel;
   logic [31:0] wdat, got, e;
   logic [15:0] m, pc, p, dd, rr16, nst;
   logic [5:0] op;
   wire logic [31:0] dat_o;
   wire logic ack_o, busy_o;
   wire logic [15:0] pc_o;
   logic [31:0] exp_q[$];
   int n_fail, num_checks, seed, i;
   cpu_arith_logic_jump_unit dut_u (.CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack_o), .BUSY(busy_o),
      .PC(pc_o));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task stop_test;
      if (n_fail == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      do
      begin
         @(posedge clk);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 40)
      begin
         n_fail++;
         stop_test;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      wb(1'b1, a, v);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      exp_q.push_back(x);
      wb(1'b0, a, 32'h0000_0000);
   endtask
   // waits out BUSY; a refused command never raises it, so the first settled sample ends the wait
   task run(input logic [31:0] c);
      int n;
      wr(8'h00, c);
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end while (busy_o !== 1'b0 && n < 20);
      if (n >= 20)
      begin
         n_fail++;
         stop_test;
      end
   endtask
   always @(posedge clk)
   begin
      if (ack_o === 1'b1 && cyc && !we)
      begin
         got = dat_o;
         e = exp_q.pop_front();
         num_checks++;
         if (got !== e)
         begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, e);
         end
         if (adr == 8'h0C && pc_o !== e[15:0])
         begin
            n_fail++;
            $display("Error t=%0t pc=%h exp=%h", $time, pc_o, e[15:0]);
         end
      end
   end
   // byte op reference: returns {sreg, result}; subtract runs as add of the complement
   function automatic logic [15:0] model(input logic [5:0] o, input logic [7:0] dv, rv, kv, sv);
      logic [7:0] a, b, x, y, f;
      logic [8:0] w;
      logic [4:0] h;
      logic sb, ci, ar;
      a = dv;
      b = rv;
      sb = 1'b0;
      ci = 1'b0;
      ar = 1'b1;
      f = sv;
      case (o)
         6'h01: ci = sv[0];
         6'h03: sb = 1'b1;
         6'h04: begin sb = 1'b1; b = kv; end
         6'h05: begin sb = 1'b1; ci = sv[0]; end
         6'h06: begin sb = 1'b1; ci = sv[0]; b = kv; end
         6'h0E: begin sb = 1'b1; a = 8'h00; b = dv; end
         6'h00: ar = 1'b1;
         default: ar = 1'b0;
      endcase
      x = sb ? ~b : b;
      w = a + x + (ci ^ sb);
      h = a[3:0] + x[3:0] + (ci ^ sb);
      y = w[7:0];
      if (ar)
      begin
         f[0] = w[8] ^ sb;
         f[5] = h[4] ^ sb;
         f[3] = (a[7] == x[7]) && (y[7] != a[7]);
      end
      else
      begin
         f[3] = 1'b0;
         case (o)
            6'h08: y = dv & rv;
            6'h09: y = dv & kv;
            6'h0A: y = dv | rv;
            6'h0B, 6'h0F: y = dv | kv;
            6'h0C: y = dv ^ rv;
            6'h0D: begin y = ~dv; f[0] = 1'b1; end
            6'h10: y = dv & ~kv;
            6'h11: begin y = dv + 8'h01; f[3] = (y == 8'h80); end
            6'h12: begin y = dv - 8'h01; f[3] = (y == 8'h7F); end
            6'h13: y = dv;
            6'h14: y = 8'h00;
            default: y = 8'hFF;
         endcase
      end
      f[1] = (y == 8'h00) && ((o == 6'h05 || o == 6'h06) ? sv[1] : 1'b1);
      f[2] = y[7];
      if (o == 6'h15)
         f = sv;
      return {f, y};
   endfunction
   task absolute_jump(input logic [5:0] o, input logic [15:0] imm, tgt, ret, input logic push, input logic [2:0] n);
      wr(8'h04, imm);
      run({26'h0, o});
      pc = tgt;
      rd(8'h0C, tgt);
      rd(8'h14, {21'h0, n, 8'h00});
      if (push)
      begin
         nst++;
         rd(8'h10, {nst, ret});
      end
   endtask
   initial
   begin
      seed = 34253;
      {nrst, cyc, stb, we, adr, wdat, nst, pc} = '0;
      sel = 4'hF;
      n_fail = 0;
      num_checks = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd(8'h08, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      wr(8'h40, $random(seed));
      rd(8'h40, 32'h0000_0000);
      for (i = 0; i < 66; i++)
      begin
         op = 6'(i % 22);
         if (op == 6'h02 || op == 6'h07)
            continue;
         {d, r, k, s} = (i < 22) ? 32'h8080_7F23 : $random(seed);
         wr(8'h88, d);
         wr(8'h8C, r);
         wr(8'h04, k);
         wr(8'h08, s);
         run({11'h0, 5'd3, 3'h0, 5'd2, 2'h0, op});
         m = model(op, d, r, k, s);
         pc++;
         rd(8'h88, m[7:0]);
         rd(8'h08, m[15:8]);
         rd(8'h0C, pc);
      end
      for (i = 0; i < 16; i++)
      begin
         {d, r, k, s} = $random(seed);
         op = (i < 4) ? (i[0] ? 6'd7 : 6'd2) : 6'(22 + i % 6);
         if (i < 2)
            {r, d, k} = i[0] ? 24'h0000_01 : 24'h7FFF_01;
         wr(8'hE0, d);
         wr(8'hE4, r);
         wr(8'hC0, d);
         wr(8'hC4, r);
         wr(8'h04, {10'h0, k[5:0]});
         wr(8'h08, s);
         m = {r, d};
         dd = (op == 6'd22 || op == 6'd25) ? {8'h00, d} : {{8{d[7]}}, d};
         rr16 = (op == 6'd23 || op == 6'd26) ? {{8{r[7]}}, r} : {8'h00, r};
         if (op < 6'd8)
         begin
            run({11'h0, 5'd0, 3'h0, 5'd24, 2'h0, op});
            p = (op == 6'd2) ? m + k[5:0] : m - k[5:0];
            s[3] = (op == 6'd2) ? ~m[15] & p[15] : m[15] & ~p[15];
            s[0] = (op == 6'd2) ? m[15] & ~p[15] : p[15] & ~m[15];
            s[4] = p[15] ^ s[3];
            s[2] = p[15];
            s[1] = (p == 16'h0000);
            rd(8'hE0, p[7:0]);
            rd(8'hE4, p[15:8]);
         end
         else
         begin
            run({11'h0, 5'd17, 3'h0, 5'd16, 2'h0, op});
            p = dd * rr16;
            s[0] = p[15];
            if (op > 6'd24)
               p = p << 1;
            s[1] = (p == 16'h0000);
            rd(8'h80, p[7:0]);
            rd(8'h84, p[15:8]);
         end
         pc++;
         rd(8'h08, s);
         rd(8'h14, 32'h0000_0200);
      end
      wr(8'h0C, 16'h0100);
      wr(8'hF8, 8'h34);
      wr(8'hFC, 8'h12);
      absolute_jump(6'd28, 16'h0FF0, 16'h00F1, 16'h0000, 1'b0, 3'd2);
      absolute_jump(6'd31, 16'h0005, pc + 16'h0006, pc + 16'h0001, 1'b1, 3'd3);
      absolute_jump(6'd29, 16'h0000, 16'h1234, 16'h0000, 1'b0, 3'd2);
      absolute_jump(6'd32, 16'h0000, 16'h1234, pc + 16'h0001, 1'b1, 3'd3);
      absolute_jump(6'd30, 16'h0ABC, 16'h0ABC, 16'h0000, 1'b0, 3'd3);
      absolute_jump(6'd33, 16'h0456, 16'h0456, pc + 16'h0002, 1'b1, 3'd4);
      run(32'h0000_0028);
      rd(8'h14, 32'h0000_0402);
      rd(8'h0C, pc);
      // second command lands inside the four busy cycles and must be dropped
      wr(8'h88, 8'h5A);
      wr(8'h04, 16'h0200);
      wr(8'h00, 32'h0000_0021);
      run({19'h0, 5'd2, 2'h0, 6'd20});
      nst++;
      rd(8'h88, 8'h5A);
      rd(8'h14, 32'h0000_0402);
      rd(8'h10, {nst, pc + 16'h0002});
      rd(8'h0C, 16'h0200);
      rd(8'h00, 32'h0000_0021);
      stop_test;
   end
   initial
   begin
      #400000;
      n_fail++;
      stop_test;
   end
endmodule
`default_nettype wire
